/* core/adc_result_port.sv */
// Purpose: result port mode logic of a 16-bit converter behind APB
// Assumes: raw result is straight binary from the conversion core
// Notes: serial port functions are outside this block
`timescale 1ns/1ns
module adc_result_port
    import adc_port_pkg::*;
#(
    parameter int MAX_INTERVAL = adc_port_pkg::MAX_INTERVAL_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [adc_port_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_start_pin,
    input wire logic [adc_port_pkg::DATA_WIDTH-1:0] raw_result,
    input wire logic raw_result_valid,
    output logic conv_start,
    output logic mode_fast,
    output logic mode_reduced_power,
    output logic [adc_port_pkg::DATA_WIDTH-1:0] result_bus_out,
    output logic [adc_port_pkg::DATA_WIDTH-1:0] result_bus_oe
);

    import adc_port_pkg::*;

    localparam int CNT_W = $clog2(MAX_INTERVAL + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MAX_INTERVAL - 1);

    logic [CTRL_WIDTH-1:0] ctrl;
    logic late_flag;
    logic undef_flag;
    logic armed;
    logic [CNT_W-1:0] interval_count;
    logic [DATA_WIDTH-1:0] last_raw;
    logic start_rise;
    conv_mode_type mode;

    // bus decode
    wire access = psel & penable;
    wire bus_write = access & pready & pwrite;
    wire hit_ctrl = paddr == ADDR_CTRL;
    wire hit_status = paddr == ADDR_STATUS;
    wire hit_result = paddr == ADDR_RESULT;
    wire hit_any = hit_ctrl | hit_status | hit_result;
    wire ctrl_write = bus_write & hit_ctrl;
    wire status_write = bus_write & hit_status;

    wire byte_order_swap = ctrl[CTRL_SWAP_BIT];
    wire output_code_format = ctrl[CTRL_FORMAT_BIT];
    wire fast_rate_select = ctrl[CTRL_FAST_BIT];
    wire low_power_select = ctrl[CTRL_LOWPWR_BIT];
    wire serial_parallel_select = ctrl[CTRL_SERIAL_BIT];

    // mode decode
    wire sel_fast = fast_rate_select & ~low_power_select;
    wire sel_reduced = low_power_select & ~fast_rate_select;
    wire sel_undef = fast_rate_select & low_power_select;

    // code format
    wire [DATA_WIDTH-1:0] coded =
        {raw_result[DATA_WIDTH-1] ^ ~output_code_format,
         raw_result[DATA_WIDTH-2:0]};
    // byte lanes
    wire [DATA_WIDTH-1:0] laned = byte_order_swap ?
        {coded[7:0], coded[15:8]} : coded;
    // parallel drive
    wire [DATA_WIDTH-1:0] next_oe =
        serial_parallel_select ? '0 : '1;

    wire [1:0] mode_code = (mode == MODE_FAST) ? STAT_MODE_FAST :
        (mode == MODE_REDUCED) ? STAT_MODE_REDUCED : STAT_MODE_NORMAL;
    wire [31:0] status_word = {28'h0000000, mode_code, undef_flag,
        late_flag};
    wire [31:0] next_prdata = !hit_any || pwrite ? 32'h00000000 :
        hit_ctrl ? {27'h0000000, ctrl} :
        hit_status ? status_word : {16'h0000, result_bus_out};

    // maximum interval check
    wire interval_expired = mode == MODE_FAST && armed && !start_rise
        && interval_count == CNT_LAST;
    wire next_late = interval_expired | (late_flag &
        ~(status_write & pwdata[STAT_LATE_BIT]));
    wire next_undef = sel_undef | (undef_flag &
        ~(status_write & pwdata[STAT_UNDEF_BIT]));

    pin_sync #(.WIDTH(1)) u_start_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(conv_start_pin),
        .level(),
        .rise(start_rise)
    );

    // mode select
    always_comb
    begin
        case ({fast_rate_select, low_power_select})
            2'b10: mode = MODE_FAST;
            2'b01: mode = MODE_REDUCED;
            2'b00: mode = MODE_NORMAL;
            default: mode = MODE_UNDEFINED;
        endcase
    end

    // apb slave, two-cycle access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            ctrl <= CTRL_RESET;
        end
        else
        begin
            pready <= access & ~pready;
            if (access && !pready)
            begin
                prdata <= next_prdata;
                pslverr <= ~hit_any;
            end
            if (ctrl_write)
            begin
                ctrl <= pwdata[CTRL_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_fast <= 1'b0;
            mode_reduced_power <= 1'b0;
            undef_flag <= 1'b0;
        end
        else
        begin
            // undefined combination falls back to normal timing
            mode_fast <= mode == MODE_FAST;
            mode_reduced_power <= mode == MODE_REDUCED;
            undef_flag <= next_undef;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_bus_out <= RESULT_RESET;
            last_raw <= RESULT_RESET;
        end
        else if (raw_result_valid)
        begin
            result_bus_out <= laned;
            last_raw <= raw_result;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_bus_oe <= '0;
        end
        else
        begin
            result_bus_oe <= next_oe;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conv_start <= 1'b0;
            armed <= 1'b0;
            interval_count <= '0;
            late_flag <= 1'b0;
        end
        else
        begin
            conv_start <= start_rise;
            late_flag <= next_late;
            if (start_rise)
            begin
                armed <= 1'b1;
                interval_count <= '0;
            end
            else if (mode != MODE_FAST || interval_expired)
            begin
                // one report per late gap, restarted by next start
                armed <= armed & (mode != MODE_FAST);
                interval_count <= '0;
            end
            else if (armed)
            begin
                interval_count <= interval_count + CNT_W'(1);
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_low_byte_lane: assert property (
        raw_result_valid && !byte_order_swap && output_code_format
        |=> result_bus_out == last_raw)
        else $error("unswapped result not on natural lanes");
    a_swapped_lanes: assert property (
        raw_result_valid && byte_order_swap && output_code_format
        |=> result_bus_out == {last_raw[7:0], last_raw[15:8]})
        else $error("swapped result lanes wrong");
    a_twos_msb: assert property (
        raw_result_valid && !byte_order_swap && !output_code_format
        |=> result_bus_out[15] != last_raw[15]
            && result_bus_out[14:0] == last_raw[14:0])
        else $error("twos complement msb not inverted");
    a_fast_mode: assert property (
        sel_fast [*2] |-> mode_fast && !mode_reduced_power)
        else $error("fast mode not reported");
    a_reduced_mode: assert property (
        sel_reduced ##1 sel_reduced |-> mode_reduced_power && !mode_fast)
        else $error("reduced power mode not reported");
    a_normal_mode: assert property (
        !fast_rate_select && !low_power_select
        |=> !mode_fast && !mode_reduced_power)
        else $error("normal mode shows another mode");
    a_serial_hiz: assert property (
        serial_parallel_select |=> result_bus_oe[1:0] == 2'h0)
        else $error("low bits driven in serial mode");
    a_parallel_drive: assert property (
        !serial_parallel_select |=> result_bus_oe[3:0] == 4'hF)
        else $error("low bits not driven in parallel mode");
    a_late_report: assert property (
        interval_expired |=> late_flag)
        else $error("late conversion not flagged");
    a_apb_answer: assert property (
        access && !pready |=> pready ##1 !pready)
        else $error("apb answer not one cycle after access");

    c_swap_seen: cover property (raw_result_valid && byte_order_swap);
    c_twos_seen: cover property (raw_result_valid && !output_code_format);
    c_serial_seen: cover property (!serial_parallel_select
        ##1 serial_parallel_select);
    c_late_seen: cover property (interval_expired);

endmodule

/* core/adc_port_pkg.sv */
// Purpose: shared constants and types for the converter result port
// Assumes: 100 MHz pclk, 32-bit APB with byte addresses
// Notes: control and status layout is local to this block
package adc_port_pkg;

    localparam int ADDR_WIDTH = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;

    localparam int CTRL_WIDTH = 5;
    localparam int CTRL_SWAP_BIT = 0;
    localparam int CTRL_FORMAT_BIT = 1;
    localparam int CTRL_FAST_BIT = 2;
    localparam int CTRL_LOWPWR_BIT = 3;
    localparam int CTRL_SERIAL_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h02;

    localparam int STAT_LATE_BIT = 0;
    localparam int STAT_UNDEF_BIT = 1;
    localparam int STAT_MODE_LSB = 2;
    localparam logic [1:0] STAT_MODE_NORMAL = 2'h0;
    localparam logic [1:0] STAT_MODE_FAST = 2'h1;
    localparam logic [1:0] STAT_MODE_REDUCED = 2'h2;

    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam int DATA_WIDTH = 16;

    localparam int CLK_FREQ_MHZ = 100;
    localparam int MAX_INTERVAL_US = 1000;
    localparam int MAX_INTERVAL_CYCLES = MAX_INTERVAL_US * CLK_FREQ_MHZ;

    typedef enum logic [1:0]
    {
        MODE_NORMAL,
        MODE_FAST,
        MODE_REDUCED,
        MODE_UNDEFINED
    } conv_mode_type;

endpackage

/* core/pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for a pin
// Assumes: pin is asynchronous to pclk
// Notes: level follows the pin once stages two and three agree
`timescale 1ns/1ns
module pin_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
    wire [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level);

    // stage1 feeds stage2 only, to keep metastability contained
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
            rise <= '0;
        end
        else
        begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
            rise <= next_level & ~level;
        end
    end

endmodule

/* bench/host_reader.sv */
// Purpose: host side reader of the converter result bus
// Assumes: each bus bit resolves from design output and enable
// Notes: a released bit reads as the inverse of its last level
`timescale 1ns/1ns
module host_reader
(
    input wire logic pclk,
    input wire logic [15:0] bus_out,
    input wire logic [15:0] bus_oe,
    output logic [15:0] bus_seen
);
    logic [15:0] last = 16'h0000;
    // resolved pin levels
    // a floating pin must never read back as the stale value
    assign bus_seen = (bus_out & bus_oe) | (~last & ~bus_oe);
    always @(posedge pclk)
        last <= (bus_out & bus_oe) | (last & ~bus_oe);
endmodule

/* bench/adc_result_port_mode_select_tb_top.sv */
// Purpose: self-checking bench for the result port mode logic
// Assumes: apb master on pclk, host_reader on the result bus
// Notes: short interval parameter keeps the late check quick
`timescale 1ns/1ns
module adc_result_port_mode_select_tb_top;
    import adc_port_pkg::*;
    localparam int MAXI = 50;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic conv_start_pin, raw_result_valid, conv_start;
    logic mode_fast, mode_reduced_power;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] raw_result, result_bus_out, result_bus_oe;
    logic [15:0] bus_seen, exp16, held;
    logic [15:0] model_q[$];
    logic [4:0] ctl;
    int n_fail, comparisons, i;

    adc_result_port #(.MAX_INTERVAL(MAXI)) dut_u
    (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .conv_start_pin, .raw_result,
        .raw_result_valid, .conv_start, .mode_fast, .mode_reduced_power,
        .result_bus_out, .result_bus_oe
    );
    host_reader host_u
    (
        .pclk, .bus_out(result_bus_out), .bus_oe(result_bus_oe),
        .bus_seen
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed, the watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // msb flip when twos complement, then optional lane swap
    function automatic logic [15:0] fmt(input logic [15:0] r,
        input logic [4:0] c);
        logic [15:0] v;
        v = r ^ {~c[CTRL_FORMAT_BIT], 15'h0000};
        return c[CTRL_SWAP_BIT] ? {v[7:0], v[15:8]} : v;
    endfunction

    task automatic summarize();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial
    begin
        #100000;
        n_fail++;
        summarize();
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_start_pin = 1'b0;
        raw_result = 16'h0000;
        raw_result_valid = 1'b0;
        n_fail = 0;
        comparisons = 0;
        void'($urandom(75611));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, {27'h0, CTRL_RESET});
        chk(result_bus_oe, 16'hFFFF);
        $display("test reset done");
        for (i = 0; i < 16; i++)
        begin
            ctl = {i[2], 2'b00, i[1], i[0]};
            apb(1'b1, ADDR_CTRL, {27'h0, ctl});
            raw_result <= 16'($urandom);
            raw_result_valid <= 1'b1;
            @(posedge pclk);
            raw_result_valid <= 1'b0;
            model_q.push_back(fmt(raw_result, ctl));
            repeat (2) @(posedge pclk);
            apb(1'b0, ADDR_RESULT, 32'h0);
            exp16 = model_q.pop_front();
            chk(rd, {16'h0, exp16});
            chk(result_bus_oe, ctl[4] ? 16'h0 : 16'hFFFF);
            if (!ctl[4])
            begin
                chk(bus_seen, exp16);
                held = exp16;
            end
            else
                chk(bus_seen[1:0], {~held[1:0]});
        end
        $display("test format done");
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, ADDR_CTRL, {27'h0, 1'b0, i[1], i[0], 2'b10});
            apb(1'b1, ADDR_STATUS, 32'h3);
            apb(1'b0, ADDR_STATUS, 32'h0);
            exp16 = (i == 1) ? 16'h4 : (i == 2) ? 16'h8 :
                (i == 3) ? 16'h2 : 16'h0;
            chk(rd, {16'h0, exp16});
            chk({mode_reduced_power, mode_fast}, {i == 2, i == 1});
        end
        $display("test modes done");
        apb(1'b1, 8'h3C, 32'h1);
        chk(err, 1'b1);
        apb(1'b0, 8'h3C, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        $display("test unmapped done");
        apb(1'b1, ADDR_CTRL, 32'h06);
        // undefined flag is sticky from the mode sweep
        apb(1'b1, ADDR_STATUS, 32'h3);
        conv_start_pin <= 1'b1;
        for (i = 0; i < 10 && conv_start !== 1'b1; i++)
            @(posedge pclk);
        chk(conv_start, 1'b1);
        conv_start_pin <= 1'b0;
        repeat (20) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h4);
        // host misses the interval on purpose
        repeat (40) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h5);
        apb(1'b1, ADDR_STATUS, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h4);
        $display("test interval done");
        summarize();
    end
endmodule
